// >>> src/scmr_pkg.sv
// Constants and types shared by the serial configuration memory readout block.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package scmr_pkg;
  // ==========================================================
  // Storage geometry.
  localparam int MEM_AW = 16;
  localparam int MEM_DEPTH = 65536;
  localparam logic [15:0] ADDR_MAX = 16'hFFFF;
  localparam logic [15:0] LOW_BLOCK_END = 16'h2000;
  localparam logic [15:0] HIGH_BLOCK_START = 16'hC000;
  // ==========================================================
  // Register port map.
  localparam int BUS_AW = 17;
  localparam int BUS_DW = 8;
  localparam logic [16:0] OFS_POL0 = 17'h10000;
  localparam logic [16:0] OFS_STAT = 17'h10004;
  localparam logic [16:0] OFS_CNT_LO = 17'h10005;
  localparam logic [16:0] OFS_CNT_HI = 17'h10006;
  localparam int POL_BYTES = 4;
  localparam logic [7:0] POL_ERASED = 8'hFF;
  localparam logic [7:0] POL_INV_CODE = 8'h5A;
  // ==========================================================
  // Pin synchroniser lanes and their idle levels.
  localparam int NSYNC = 8;
  localparam int IDX_SCLK = 0;
  localparam int IDX_CS = 1;
  localparam int IDX_ROE = 2;
  localparam int IDX_SEL = 3;
  localparam int IDX_WG = 4;
  localparam int IDX_PWG = 5;
  localparam int IDX_PSI = 6;
  localparam int IDX_DATA = 7;
  localparam logic [7:0] SYNC_RST = 8'h0A;
  // ==========================================================
  // Timing.
  localparam int CLK_NS = 10;
  localparam int POR_NS = 1000;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_HALF_NS = 50;
  localparam int OSC_HALF_CYC = (OSC_HALF_NS / CLK_NS < 1) ? 1 : OSC_HALF_NS / CLK_NS;
  localparam int CNT_W = 8;
  // ==========================================================
  // Top-level modes.
  typedef enum logic [1:0] {
    SCMR_POR = 2'b00,
    SCMR_RUN = 2'b01,
    SCMR_PROG = 2'b10
  } scmr_state_t;
endpackage : scmr_pkg

// >>> src/scmr_mem_if.sv
// Bundle between the readout logic and the bit store.
// Assumes both ends share the block clock.
`timescale 1ns/100ps
`default_nettype none
interface scmr_mem_if;
  logic [15:0] rd_addr;
  logic rd_bit;
  logic [15:0] bus_addr;
  logic bus_bit;
  logic wr_en;
  logic [15:0] wr_addr;
  logic wr_bit;
  modport mem (input rd_addr, input bus_addr, input wr_en, input wr_addr, input wr_bit,
    output rd_bit, output bus_bit);
  modport user (output rd_addr, output bus_addr, output wr_en, output wr_addr,
    output wr_bit, input rd_bit, input bus_bit);
endinterface : scmr_mem_if
`default_nettype wire

// >>> src/scmr_sync.sv
// Three-stage synchronisers for every pin input of the readout block.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module scmr_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [scmr_pkg::NSYNC-1:0] raw,
  output logic [scmr_pkg::NSYNC-1:0] stable
);
  logic [scmr_pkg::NSYNC-1:0] s1;
  logic [scmr_pkg::NSYNC-1:0] s2;
  logic [scmr_pkg::NSYNC-1:0] s3;
  genvar g;
  generate
    for (g = 0; g < scmr_pkg::NSYNC; g = g + 1)
    begin : g_lane
      // A new level is taken only once the second and third stage agree.
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          s1[g] <= scmr_pkg::SYNC_RST[g];
          s2[g] <= scmr_pkg::SYNC_RST[g];
          s3[g] <= scmr_pkg::SYNC_RST[g];
          stable[g] <= scmr_pkg::SYNC_RST[g];
        end
        else
        begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g])
            stable[g] <= s3[g];
        end
      end
    end
  endgenerate
endmodule : scmr_sync
`default_nettype wire

// >>> src/scmr_mem.sv
// Bit-wide configuration store with one readout port and one register-port read.
// Assumes writes are already filtered for protection by the caller.
`timescale 1ns/100ps
`default_nettype none
module scmr_mem (
  input wire logic clk,
  scmr_mem_if.mem m
);
  logic store [scmr_pkg::MEM_DEPTH];
  // Both read ports are combinational; the caller registers them.
  assign m.rd_bit = store[m.rd_addr];
  assign m.bus_bit = store[m.bus_addr];
  always_ff @(posedge clk)
  begin
    if (m.wr_en)
      store[m.wr_addr] <= m.wr_bit;
  end
endmodule : scmr_mem
`default_nettype wire

// >>> src/scmr_top.sv
// Serial configuration memory readout: bit counter, pin control and register port.
// Assumes pins arrive asynchronously; the register port is on clk.
//
// How it works
// - Serial clock rise advances counter, shows bit.
// - Count only enabled, selected, not finished.
// - Reset level clears counter, floats data.
// - Select high after reset halts and floats.
// - Float data once image sent, cascade low.
// - Power-up clears counter without external reset.
// - Cascade output low on edge after maximum count.
// - Select low at reset makes chain master.
// - Master stops oscillator, holds clock low.
// - Reset polarity programmable, default enable high.
// - Polarity kept in four bytes, erased by reset.
// - Mode select low enters programming mode.
// - Write guard high protects lowest block while select is low.
// - Partial guard only in programming, default off.
// - Programming select only acts in programming.
// - Ready pulled low during power-on reset.
// - Data tri-state readout, open-collector programming.
// - Edge after last bit ends driving.
// - Select high means standby, data floats.
`timescale 1ns/100ps
`default_nettype none
module scmr_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock_i,
  output logic serial_clock_o,
  output logic serial_clock_oe,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe,
  input wire logic chip_select_low,
  input wire logic reset_output_enable,
  input wire logic program_mode_select,
  input wire logic write_guard,
  input wire logic partial_write_guard,
  input wire logic program_select_input,
  output logic cascade_select_out,
  output logic ready_o,
  output logic ready_oe,
  input wire logic [16:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ==========================================================
  // Pin synchronisers.
  logic [7:0] pin_raw;
  logic [7:0] pin_s;
  assign pin_raw = {data_i, program_select_input, partial_write_guard, write_guard,
    program_mode_select, reset_output_enable, chip_select_low, serial_clock_i};

  scmr_sync u_sync (
    .clk(clk),
    .rst(rst),
    .raw(pin_raw),
    .stable(pin_s)
  );

  logic sclk_s;
  logic cs_low_s;
  logic roe_s;
  logic sel_s;
  logic wg_s;
  logic pwg_s;
  logic psi_s;
  logic din_s;
  assign sclk_s = pin_s[scmr_pkg::IDX_SCLK];
  assign cs_low_s = pin_s[scmr_pkg::IDX_CS];
  assign roe_s = pin_s[scmr_pkg::IDX_ROE];
  assign sel_s = pin_s[scmr_pkg::IDX_SEL];
  assign wg_s = pin_s[scmr_pkg::IDX_WG];
  assign pwg_s = pin_s[scmr_pkg::IDX_PWG];
  assign psi_s = pin_s[scmr_pkg::IDX_PSI];
  assign din_s = pin_s[scmr_pkg::IDX_DATA];

  // ==========================================================
  // Bit store.
  scmr_mem_if mem ();

  scmr_mem u_mem (
    .clk(clk),
    .m(mem.mem)
  );

  // ==========================================================
  // State.
  scmr_pkg::scmr_state_t state;
  scmr_pkg::scmr_state_t next_state;
  logic [scmr_pkg::CNT_W-1:0] por_cnt;
  logic [scmr_pkg::CNT_W-1:0] osc_cnt;
  logic [scmr_pkg::MEM_AW-1:0] addr;
  logic done;
  logic is_master;
  logic sclk_prev;
  logic [7:0] pol_byte [scmr_pkg::POL_BYTES];

  // ==========================================================
  // Decode helpers.
  function automatic logic ctrl_hit(input logic [16:0] a, input logic [16:0] ofs);
    ctrl_hit = (a == ofs);
  endfunction : ctrl_hit

  function automatic logic pol_hit(input logic [16:0] a, input int idx);
    pol_hit = (a == scmr_pkg::OFS_POL0 + 17'(idx));
  endfunction : pol_hit

  // Inverted polarity only when all four bytes carry the code, so a torn write
  // leaves the default.
  logic pol_inv;
  assign pol_inv = (pol_byte[0] == scmr_pkg::POL_INV_CODE)
    && (pol_byte[1] == scmr_pkg::POL_INV_CODE)
    && (pol_byte[2] == scmr_pkg::POL_INV_CODE)
    && (pol_byte[3] == scmr_pkg::POL_INV_CODE);

  logic roe_active;
  logic in_reset;
  logic loading;
  logic prog_mode;
  assign roe_active = roe_s ^ pol_inv;
  assign in_reset = !roe_active;
  assign prog_mode = !sel_s;
  assign loading = (state == scmr_pkg::SCMR_RUN);

  // ==========================================================
  // Counting conditions and clock edges.
  logic count_ok;
  logic ext_rise;
  logic osc_run;
  logic osc_tick;
  logic own_rise;
  logic step;
  logic at_max;
  assign count_ok = loading && roe_active && !cs_low_s && !done;
  assign ext_rise = sclk_s && !sclk_prev;
  assign osc_run = is_master && count_ok;
  assign osc_tick = osc_run && (osc_cnt == 8'(scmr_pkg::OSC_HALF_CYC - 1));
  assign own_rise = osc_tick && !serial_clock_o;
  assign step = count_ok && (is_master ? own_rise : ext_rise);
  assign at_max = (addr == scmr_pkg::ADDR_MAX);

  // ==========================================================
  // Register port writes with protection.
  logic wr_ok;
  logic mem_sel;
  logic guard_low;
  logic guard_high;
  logic mem_wr;
  assign wr_ok = reg_wr && (state == scmr_pkg::SCMR_PROG) && psi_s;
  assign mem_sel = !reg_addr[16];
  assign guard_low = wg_s && !cs_low_s && (reg_addr[15:0] < scmr_pkg::LOW_BLOCK_END);
  assign guard_high = pwg_s && (reg_addr[15:0] >= scmr_pkg::HIGH_BLOCK_START);
  assign mem_wr = wr_ok && mem_sel && !guard_low && !guard_high;

  assign mem.rd_addr = addr;
  assign mem.bus_addr = reg_addr[15:0];
  assign mem.wr_en = mem_wr;
  assign mem.wr_addr = reg_addr[15:0];
  assign mem.wr_bit = reg_wdata[0];

  // ==========================================================
  // Register port read selection.
  logic [7:0] status;
  logic [7:0] next_rdata;
  assign status = {cs_low_s, (state != scmr_pkg::SCMR_POR), roe_active, din_s,
    (state == scmr_pkg::SCMR_PROG), pol_inv, is_master, done};
  assign next_rdata = mem_sel ? {7'h00, mem.bus_bit} :
    pol_hit(reg_addr, 0) ? pol_byte[0] :
    pol_hit(reg_addr, 1) ? pol_byte[1] :
    pol_hit(reg_addr, 2) ? pol_byte[2] :
    pol_hit(reg_addr, 3) ? pol_byte[3] :
    ctrl_hit(reg_addr, scmr_pkg::OFS_STAT) ? status :
    ctrl_hit(reg_addr, scmr_pkg::OFS_CNT_LO) ? addr[7:0] :
    ctrl_hit(reg_addr, scmr_pkg::OFS_CNT_HI) ? addr[15:8] : 8'h00;

  // ==========================================================
  // Mode sequencing.
  always_comb
  begin
    next_state = state;
    case (state)
      scmr_pkg::SCMR_POR:
      begin
        if (por_cnt == 8'(scmr_pkg::POR_CYC - 1))
          next_state = prog_mode ? scmr_pkg::SCMR_PROG : scmr_pkg::SCMR_RUN;
      end
      scmr_pkg::SCMR_RUN:
      begin
        if (prog_mode)
          next_state = scmr_pkg::SCMR_PROG;
      end
      scmr_pkg::SCMR_PROG:
      begin
        if (!prog_mode)
          next_state = scmr_pkg::SCMR_RUN;
      end
      default:
        next_state = scmr_pkg::SCMR_POR;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= scmr_pkg::SCMR_POR;
      por_cnt <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (state == scmr_pkg::SCMR_POR)
        por_cnt <= por_cnt + 8'h01;
    end
  end

  // ==========================================================
  // Address counter, end of image and chain role.
  always_ff @(posedge clk)
  begin
    if (rst || state == scmr_pkg::SCMR_POR)
    begin
      addr <= 16'h0000;
      done <= 1'b0;
    end
    else if (in_reset)
    begin
      addr <= 16'h0000;
      done <= 1'b0;
    end
    else if (step)
    begin
      if (at_max)
        done <= 1'b1;
      else
        addr <= addr + 16'h0001;
    end
  end

  // The role is caught while the reset level is applied and at power-up.
  always_ff @(posedge clk)
  begin
    if (rst)
      is_master <= 1'b0;
    else if (state == scmr_pkg::SCMR_POR || in_reset)
      is_master <= !cs_low_s;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk_s;
  end

  // ==========================================================
  // Polarity bytes; erased at power-up, which gives the default polarity.
  genvar p;
  generate
    for (p = 0; p < scmr_pkg::POL_BYTES; p = p + 1)
    begin : g_pol
      always_ff @(posedge clk)
      begin
        if (rst)
          pol_byte[p] <= scmr_pkg::POL_ERASED;
        else if (wr_ok && pol_hit(reg_addr, p))
          pol_byte[p] <= reg_wdata;
      end
    end
  endgenerate

  // ==========================================================
  // Master oscillator on the serial clock pin.
  always_ff @(posedge clk)
  begin
    if (rst || !osc_run)
    begin
      osc_cnt <= 8'h00;
      serial_clock_o <= 1'b0;
    end
    else if (osc_tick)
    begin
      osc_cnt <= 8'h00;
      serial_clock_o <= !serial_clock_o;
    end
    else
      osc_cnt <= osc_cnt + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      serial_clock_oe <= 1'b0;
    else
      serial_clock_oe <= is_master && loading;
  end

  // ==========================================================
  // Data pin: tri-state during readout, open-collector acknowledge in programming.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_o <= 1'b0;
      data_oe <= 1'b0;
    end
    else if (state == scmr_pkg::SCMR_PROG)
    begin
      data_o <= 1'b0;
      data_oe <= mem_wr;
    end
    else
    begin
      data_o <= mem.rd_bit;
      data_oe <= count_ok;
    end
  end

  // ==========================================================
  // Cascade output and ready indicator.
  always_ff @(posedge clk)
  begin
    if (rst)
      cascade_select_out <= 1'b1;
    else
      cascade_select_out <= !done;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready_o <= 1'b0;
      ready_oe <= 1'b1;
    end
    else
    begin
      ready_o <= 1'b0;
      ready_oe <= (state == scmr_pkg::SCMR_POR);
    end
  end

  // ==========================================================
  // Register port read data, valid the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end
endmodule : scmr_top
`default_nettype wire

// >>> test/scmr_loader.sv
// Far-side loader model: clocks the serial clock pin and captures data bits.
// Assumes the device is a chain slave; its data pin has no pull resistor.
`timescale 1ns/100ps
`default_nettype none
module scmr_loader (
  input wire logic clk,
  input wire logic run,
  input wire logic data_o,
  input wire logic data_oe,
  output logic sclk,
  output logic data_pin
);
  // ==========================================================
  // Clock stands low outside frames; a floated pin shows the inverse.
  int ph = 0;
  logic last = 1'b0;
  logic got[$];
  initial sclk = 1'b0;
  assign data_pin = data_oe ? data_o : ~last;
  always @(posedge clk)
  begin
    if (data_oe)
      last <= data_o;
    ph <= run ? (ph + 1) % 10 : 0;
    sclk <= run && (ph >= 5);
    if (run && ph == 5 && data_oe)
      got.push_back(data_pin);
  end
endmodule : scmr_loader
`default_nettype wire

// >>> test/scmr_top_sva.sv
// Checker for the readout block, seeing only its top ports.
// Assumes the default reset-enable polarity and one clock domain.
`timescale 1ns/100ps
`default_nettype none
module scmr_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_low,
  input wire logic reset_output_enable,
  input wire logic program_mode_select,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic serial_clock_o,
  input wire logic serial_clock_oe,
  input wire logic cascade_select_out,
  input wire logic ready_o,
  input wire logic ready_oe
);
  // ==========================================================
  // Properties.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_values: assert property ($fell(rst) |->
    !data_oe && cascade_select_out && ready_oe && !serial_clock_oe) else $error("bad reset");
  a_ready_por: assert property ($fell(rst) |-> (ready_oe && !ready_o) [*8])
    else $error("ready released early");
  a_reset_float: assert property ((!reset_output_enable && program_mode_select) [*7]
    |-> !data_oe) else $error("data driven in reset");
  a_select_float: assert property ((chip_select_low && program_mode_select) [*7]
    |-> !data_oe) else $error("data driven in standby");
  a_casc_float: assert property ($fell(cascade_select_out) |-> !data_oe)
    else $error("data driven after cascade");
  a_prog_ack: assert property (!program_mode_select [*8] ##0 data_oe |-> !data_o)
    else $error("ack not low");
  a_clock_halt: assert property (((!reset_output_enable || chip_select_low)
    && program_mode_select) [*7] |-> !serial_clock_o) else $error("clock not halted");
  a_standby_hold: assert property ((chip_select_low && program_mode_select) [*8]
    |-> $stable(data_o)) else $error("data stepped in standby");
endmodule : scmr_top_sva
bind scmr_top scmr_top_sva scmr_top_sva_inst (.clk, .rst, .chip_select_low,
  .reset_output_enable, .program_mode_select, .data_o, .data_oe, .serial_clock_o,
  .serial_clock_oe, .cascade_select_out, .ready_o, .ready_oe);
`default_nettype wire

// >>> test/serial_config_memory_readout_tb.sv
// Self-checking bench: register port programming, then slave readout via the loader.
// Assumes a 100 MHz clock and the default reset-enable polarity.
`timescale 1ns/100ps
`default_nettype none
module serial_config_memory_readout_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chip_select_low = 1'b1;
  logic reset_output_enable = 1'b1;
  logic program_mode_select = 1'b1;
  logic write_guard = 1'b0;
  logic partial_write_guard = 1'b0;
  logic program_select_input = 1'b0;
  logic [16:0] reg_addr = 17'h00000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [7:0] reg_rdata;
  logic serial_clock_o, serial_clock_oe, data_o, data_oe, cascade_select_out;
  logic ready_o, ready_oe, sclk, data_pin, sclk_pin;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'he467;
  int exp_bit[32];
  int i;
  int osc_steps;
  assign sclk_pin = serial_clock_oe ? serial_clock_o : sclk;
  always #5 clk = ~clk;
  scmr_top scmr_top_inst (.clk(clk), .rst(rst), .serial_clock_i(sclk_pin),
    .serial_clock_o(serial_clock_o), .serial_clock_oe(serial_clock_oe), .data_i(data_pin),
    .data_o(data_o), .data_oe(data_oe), .chip_select_low(chip_select_low),
    .reset_output_enable(reset_output_enable), .program_mode_select(program_mode_select),
    .write_guard(write_guard), .partial_write_guard(partial_write_guard),
    .program_select_input(program_select_input), .cascade_select_out(cascade_select_out),
    .ready_o(ready_o), .ready_oe(ready_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  scmr_loader scmr_loader_inst (.clk(clk), .run(run), .data_o(data_o), .data_oe(data_oe),
    .sclk(sclk), .data_pin(data_pin));
  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [16:0] a, input logic [7:0] d, input logic ack);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 chk(16'(data_oe), 16'(ack));
  endtask : wr
  task automatic rdc(input logic [16:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata & m), 16'(e));
  endtask : rdc
  task automatic edges(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n * 10) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : edges
  task automatic stream(input int n);
    chk(16'(scmr_loader_inst.got.size()), 16'(n));
    for (int k = 0; k < n && k < scmr_loader_inst.got.size(); k++)
      chk(16'(scmr_loader_inst.got[k]), 16'(exp_bit[k]));
    scmr_loader_inst.got.delete();
  endtask : stream
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  // ==========================================================
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(16'(ready_oe), 16'h0001);
    chk(16'(ready_o), 16'h0000);
    repeat (110) @(posedge clk);
    #1 chk(16'(ready_oe), 16'h0000);
    rdc(scmr_pkg::OFS_CNT_LO, 8'h00);
    rdc(scmr_pkg::OFS_STAT, 8'h20, 8'h24);
    for (i = 0; i < 4; i++)
      rdc(scmr_pkg::OFS_POL0 + 17'(i), scmr_pkg::POL_ERASED);
    rdc(17'h1FFFF, 8'h00);
    program_mode_select <= 1'b0;
    program_select_input <= 1'b1;
    chip_select_low <= 1'b0;
    repeat (8) @(posedge clk);
    for (i = 0; i < 32; i++)
    begin
      exp_bit[i] = $random(seed) & 1;
      wr(17'(i), 8'(exp_bit[i]), 1'b1);
    end
    wr(17'(scmr_pkg::HIGH_BLOCK_START), 8'h00, 1'b1);
    // Polarity flips only once all four bytes hold the code.
    for (i = 0; i < 3; i++)
      wr(scmr_pkg::OFS_POL0 + 17'(i), scmr_pkg::POL_INV_CODE, 1'b0);
    rdc(scmr_pkg::OFS_STAT, 8'h20, 8'h24);
    wr(scmr_pkg::OFS_POL0 + 17'h00003, scmr_pkg::POL_INV_CODE, 1'b0);
    rdc(scmr_pkg::OFS_STAT, 8'h04, 8'h24);
    rdc(scmr_pkg::OFS_POL0 + 17'h00003, scmr_pkg::POL_INV_CODE);
    wr(scmr_pkg::OFS_POL0, scmr_pkg::POL_ERASED, 1'b0);
    rdc(scmr_pkg::OFS_STAT, 8'h20, 8'h24);
    write_guard <= 1'b1;
    partial_write_guard <= 1'b1;
    repeat (6) @(posedge clk);
    wr(17'h00000, 8'(1 - exp_bit[0]), 1'b0);
    wr(17'h02000, 8'h01, 1'b1);
    wr(17'(scmr_pkg::HIGH_BLOCK_START), 8'h01, 1'b0);
    write_guard <= 1'b0;
    partial_write_guard <= 1'b0;
    program_select_input <= 1'b0;
    repeat (6) @(posedge clk);
    wr(17'h00001, 8'(1 - exp_bit[1]), 1'b0);
    for (i = 0; i < 32; i++)
      rdc(17'(i), 8'(exp_bit[i]));
    rdc(17'h02000, 8'h01);
    rdc(17'(scmr_pkg::HIGH_BLOCK_START), 8'h00);
    // Leave programming as a chain slave: select high while reset is applied.
    program_mode_select <= 1'b1;
    chip_select_low <= 1'b1;
    reset_output_enable <= 1'b0;
    repeat (8) @(posedge clk);
    reset_output_enable <= 1'b1;
    edges(4);
    stream(0);
    rdc(scmr_pkg::OFS_CNT_LO, 8'h00);
    chip_select_low <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(16'(data_oe), 16'h0001);
    edges(16);
    stream(16);
    chk(16'(cascade_select_out), 16'h0001);
    rdc(scmr_pkg::OFS_CNT_LO, 8'h10);
    chip_select_low <= 1'b1;
    edges(4);
    rdc(scmr_pkg::OFS_CNT_LO, 8'h10);
    reset_output_enable <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(16'(data_oe), 16'h0000);
    rdc(scmr_pkg::OFS_CNT_LO, 8'h00);
    reset_output_enable <= 1'b1;
    chip_select_low <= 1'b0;
    repeat (8) @(posedge clk);
    edges(4);
    stream(4);
    rdc(scmr_pkg::OFS_CNT_HI, 8'h00);
    // Chain master: select low while the reset level is applied, then 100 cycles of
    // counting on the own oscillator, one rise per full oscillator period.
    reset_output_enable <= 1'b0;
    repeat (8) @(posedge clk);
    reset_output_enable <= 1'b1;
    repeat (100) @(posedge clk);
    chip_select_low <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(16'(serial_clock_oe), 16'h0001);
    chk(16'(serial_clock_o), 16'h0000);
    osc_steps = (100 + scmr_pkg::OSC_HALF_CYC) / (2 * scmr_pkg::OSC_HALF_CYC);
    rdc(scmr_pkg::OFS_CNT_LO, 8'(osc_steps));
    end_of_test();
  end
endmodule : serial_config_memory_readout_tb
`default_nettype wire
